//--- common/pdcr_cfg.svh
// constants for the divider configuration register bank
`ifndef PDCR_CFG_SVH
`define PDCR_CFG_SVH
`define PDCR_WORD_W 24
`define PDCR_SEL_W 3
`define PDCR_SEL_WHOLE 3'h0
`define PDCR_SEL_DENOM 3'h1
`define PDCR_SEL_NUMER 3'h2
`define PDCR_WHOLE_LSB 3
`define PDCR_WHOLE_MSB 9
`define PDCR_STYLE_BIT 10
`define PDCR_FIELD_LSB 3
`define PDCR_FIELD_MSB 13
`define PDCR_RST_WHOLE 24'h0001C0
`define PDCR_RST_DENOM 24'h003001
`define PDCR_RST_NUMER 24'h001802
`define PDCR_INT_MIN 7'h15
`define PDCR_INT_MAX 7'h7B
`define PDCR_FRAC_MIN 7'h18
`define PDCR_FRAC_MAX 7'h77
`endif

//--- common/pdcr_pkg.sv
// types for the divider configuration register bank
package pdcr_pkg;
  typedef logic [23:0] pdcr_word_t;
  typedef logic [2:0] pdcr_sel_t;
  typedef enum logic [1:0] {
    PDCR_FRACTIONAL = 2'h1,
    PDCR_INTEGER = 2'h2
  } pdcr_style_e;
endpackage

//--- core/pdcr_bank.sv
// divider configuration registers loaded from the serial port
`timescale 1ns/10ps
`default_nettype none
`include "pdcr_cfg.svh"
module pdcr_bank
  import pdcr_pkg::*;
#(
  parameter int WORD_W = `PDCR_WORD_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sle,
  output logic [6:0] whole_ratio_bits,
  output logic divide_style_select,
  output logic [10:0] denominator_bits,
  output logic [10:0] numerator_bits,
  output logic ratio_legal,
  output logic [23:0] whole_ratio_divide_control,
  output logic [23:0] fraction_denominator_control,
  output logic [23:0] fraction_numerator_control
);
  if (WORD_W != `PDCR_WORD_W) begin : g_bad_width
    $error("pdcr_bank: word width must be 24");
  end

  pdcr_word_t lword;
  logic ltgl;

  pdcr_shift #(.WORD_W(WORD_W)) u_shift (
    .sclk(sclk),
    .sdata(sdata),
    .sle(sle),
    .word(lword),
    .word_tgl(ltgl)
  );

  // toggle crossing; word changes with the toggle and is stable before it clears the sync flops
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  pdcr_word_t hold_reg;
  pdcr_word_t hold_next;
  logic ev_reg;
  logic ev_next;

  always_comb begin
    sync_next = {sync_reg[1:0], ltgl};
    ev_next = sync_reg[2] ^ sync_reg[1];
    hold_next = hold_reg;
    if (sync_reg[2] ^ sync_reg[1]) begin
      hold_next = lword;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // keep tracking the toggle so its level after reset is no event
      sync_reg <= sync_next;
      ev_reg <= 1'b0;
      hold_reg <= 24'h000000;
    end else begin
      sync_reg <= sync_next;
      ev_reg <= ev_next;
      hold_reg <= hold_next;
    end
  end

  pdcr_word_t whole_reg;
  pdcr_word_t whole_next;
  pdcr_word_t denom_reg;
  pdcr_word_t denom_next;
  pdcr_word_t numer_reg;
  pdcr_word_t numer_next;
  pdcr_sel_t sel;

  always_comb begin
    sel = hold_reg[`PDCR_SEL_W-1:0];
    whole_next = whole_reg;
    denom_next = denom_reg;
    numer_next = numer_reg;
    if (ev_reg) begin
      unique case (sel)
        `PDCR_SEL_WHOLE: whole_next = hold_reg;
        `PDCR_SEL_DENOM: denom_next = hold_reg;
        `PDCR_SEL_NUMER: numer_next = hold_reg;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      whole_reg <= `PDCR_RST_WHOLE;
      denom_reg <= `PDCR_RST_DENOM;
      numer_reg <= `PDCR_RST_NUMER;
    end else begin
      whole_reg <= whole_next;
      denom_reg <= denom_next;
      numer_reg <= numer_next;
    end
  end

  // decoded fields, reserved bits dropped
  logic [6:0] ratio;
  logic [10:0] den;
  logic [10:0] num;
  pdcr_style_e style;
  logic legal;
  always_comb begin
    ratio = whole_reg[`PDCR_WHOLE_MSB:`PDCR_WHOLE_LSB];
    den = denom_reg[`PDCR_FIELD_MSB:`PDCR_FIELD_LSB];
    num = numer_reg[`PDCR_FIELD_MSB:`PDCR_FIELD_LSB];
    style = whole_reg[`PDCR_STYLE_BIT] ? PDCR_INTEGER : PDCR_FRACTIONAL;
    legal = 1'b0;
    unique case (style)
      PDCR_INTEGER: legal = (ratio >= `PDCR_INT_MIN) &&
                            (ratio <= `PDCR_INT_MAX);
      // fractional range, also requires a nonzero den and num below den
      PDCR_FRACTIONAL: legal = (ratio >= `PDCR_FRAC_MIN) &&
                               (ratio <= `PDCR_FRAC_MAX) &&
                               (den != 11'h000) && (num < den);
      default: legal = 1'b0;
    endcase
  end

  logic [6:0] ratio_o_reg;
  logic style_o_reg;
  logic [10:0] den_o_reg;
  logic [10:0] num_o_reg;
  logic legal_o_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ratio_o_reg <= 7'h38;
      style_o_reg <= 1'b0;
      den_o_reg <= 11'h600;
      num_o_reg <= 11'h300;
      legal_o_reg <= 1'b1;
    end else begin
      ratio_o_reg <= ratio;
      style_o_reg <= (style == PDCR_INTEGER);
      den_o_reg <= den;
      num_o_reg <= num;
      legal_o_reg <= legal;
    end
  end

  assign whole_ratio_bits = ratio_o_reg;
  assign divide_style_select = style_o_reg;
  assign denominator_bits = den_o_reg;
  assign numerator_bits = num_o_reg;
  assign ratio_legal = legal_o_reg;
  assign whole_ratio_divide_control = whole_reg;
  assign fraction_denominator_control = denom_reg;
  assign fraction_numerator_control = numer_reg;
endmodule
`default_nettype wire

//--- core/pdcr_shift.sv
// serial shift-in on the link clock with word handoff to mclk
`timescale 1ns/10ps
`default_nettype none
module pdcr_shift
  import pdcr_pkg::*;
#(
  parameter int WORD_W = 24
) (
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sle,
  output logic [WORD_W-1:0] word,
  output logic word_tgl
);
  if (WORD_W != 24) begin : g_bad_width
    $error("pdcr_shift: word width must be 24");
  end

  logic [WORD_W-1:0] sh_reg;
  logic [WORD_W-1:0] sh_next;
  // power-up values: the link side has no reset, an unknown toggle
  // or count would never recover
  logic [5:0] cnt_reg = 6'h00;
  logic [5:0] cnt_next;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic tgl_reg = 1'b0;
  logic tgl_next;

  // shift msb first while latch enable is low; le rise ends the frame
  always_comb begin
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    tgl_next = tgl_reg;
    if (!sle) begin
      sh_next = {sh_reg[WORD_W-2:0], sdata};
      if (cnt_reg != 6'h3F) begin
        cnt_next = cnt_reg + 6'h01;
      end
    end else if (cnt_reg != 6'h00) begin
      if (cnt_reg == 6'(WORD_W)) begin
        word_next = sh_reg;
        tgl_next = ~tgl_reg;
      end
      cnt_next = 6'h00;
    end
  end

  // no reset here: link clock may not run during mclk reset
  always_ff @(posedge sclk) begin
    sh_reg <= sh_next;
    cnt_reg <= cnt_next;
    word_reg <= word_next;
    tgl_reg <= tgl_next;
  end

  assign word = word_reg;
  assign word_tgl = tgl_reg;
endmodule
`default_nettype wire

//--- dv/pdcr_host.sv
// serial host model driving the three-pin port
`timescale 1ns/10ps
`default_nettype none
module pdcr_host
  import pdcr_pkg::*;
(
  output logic sclk,
  output logic sdata,
  output logic sle
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    sle = 1'b1;
  end
  task automatic send(input pdcr_word_t w, input int n);
    sle = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata = w[i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    // data inverted so a stale level is never read as valid
    sle = 1'b1;
    sdata = ~sdata;
    #6 sclk = 1'b1;
    #6 sclk = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/pdcr_props.sv
// checker for the divider register bank
`timescale 1ns/10ps
`default_nettype none
module pdcr_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [6:0] whole_ratio_bits,
  input wire logic divide_style_select,
  input wire logic [10:0] denominator_bits,
  input wire logic [10:0] numerator_bits,
  input wire logic ratio_legal,
  input wire logic [23:0] whole_ratio_divide_control,
  input wire logic [23:0] fraction_denominator_control,
  input wire logic [23:0] fraction_numerator_control
);
  wire [23:0] w0 = whole_ratio_divide_control;
  wire [23:0] w1 = fraction_denominator_control;
  wire [23:0] w2 = fraction_numerator_control;
  wire [6:0] r = whole_ratio_bits;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_whole_sel: assert property ($changed(w0) |-> w0[2:0] == 3'h0)
    else $error("whole word hit by other select");
  a_denom_sel: assert property ($changed(w1) |-> w1[2:0] == 3'h1)
    else $error("denominator word hit by other select");
  a_numer_sel: assert property ($changed(w2) |-> w2[2:0] == 3'h2)
    else $error("numerator word hit by other select");
  a_whole_field: assert property (
    {divide_style_select, r} == $past(w0[10:3]))
    else $error("ratio or style field wrong");
  a_denom_field: assert property (denominator_bits == $past(w1[13:3]))
    else $error("denominator field wrong");
  a_numer_field: assert property (numerator_bits == $past(w2[13:3]))
    else $error("numerator field wrong");
  a_legal_int: assert property (divide_style_select |->
    ratio_legal == (r >= 7'd21 && r <= 7'd123)) else $error("int legal");
  a_legal_frac: assert property (!divide_style_select |->
    ratio_legal == (r >= 7'd24 && r <= 7'd119 &&
    denominator_bits != 11'h000 &&
    numerator_bits < denominator_bits)) else $error("frac legal");
endmodule
bind pdcr_bank pdcr_props chk (.*);
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the divider register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pdcr_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wire sclk, sdata, sle, dss, legal;
  wire [6:0] wr;
  wire [10:0] dn, nm;
  wire [23:0] c0, c1, c2;
  pdcr_word_t e [3];
  pdcr_word_t w;
  logic [10:0] v;
  logic [31:0] x = 32'hB9E8;
  logic [6:0] lim [8] = '{20, 21, 123, 124, 23, 24, 119, 120};
  int bad_count = 0;
  int samples_checked = 0;
  always #4 mclk = ~mclk;
  pdcr_host host (.sclk(sclk), .sdata(sdata), .sle(sle));
  pdcr_bank DUT (.mclk(mclk), .rst(rst), .sclk(sclk), .sdata(sdata),
    .sle(sle), .whole_ratio_bits(wr), .divide_style_select(dss),
    .denominator_bits(dn), .numerator_bits(nm), .ratio_legal(legal),
    .whole_ratio_divide_control(c0), .fraction_denominator_control(c1),
    .fraction_numerator_control(c2));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic legal_of(pdcr_word_t a, d, n);
    if (a[10]) return a[9:3] >= 21 && a[9:3] <= 123;
    return a[9:3] >= 24 && a[9:3] <= 119 && d[13:3] != 0 &&
      n[13:3] < d[13:3];
  endfunction
  task automatic check(string s, logic [23:0] seen, logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic cmp();
    check("whole", c0, e[0]);
    check("denom", c1, e[1]);
    check("numer", c2, e[2]);
    check("ratio", 24'({dss, wr}), 24'(e[0][10:3]));
    check("den", 24'(dn), 24'(e[1][13:3]));
    check("num", 24'(nm), 24'(e[2][13:3]));
    check("legal", 24'(legal), 24'(legal_of(e[0], e[1], e[2])));
  endtask
  // phase offset keeps the link clock unrelated to mclk
  task automatic put(input pdcr_word_t w, input int n);
    @(posedge mclk);
    #3 host.send(w, n);
    repeat (10) @(posedge mclk);
    if (n == 24 && w[2:0] < 3) e[w[2:0]] = w;
    cmp();
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  initial begin
    e = '{24'h0001C0, 24'h003001, 24'h001802};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp();
    $display("test reset done");
    // first pass from select 7 down to 0
    for (int s = 7; s >= 0; s--)
      put(s < 3 ? e[s] : {x[20:0], 3'(s)}, 24);
    put(24'h0004A8, 23);
    put(24'h8003B8, 24);
    $display("test codes done");
    for (int i = 0; i < 8; i++)
      put({13'h0, i < 4, lim[i], 3'h0}, 24);
    $display("test corner done");
    for (int k = 0; k < 40; k++) begin
      x = lfsr(x);
      v = x[13:3];
      case (x[17:16] % 3)
        0: w = {13'h0, x[10:3], 3'h0};
        1: w = {10'h0, v > e[2][13:3] ? v : e[2][13:3] + 11'h1, 3'h1};
        default: w = {10'h0, v % e[1][13:3], 3'h2};
      endcase
      put(w, 24);
    end
    $display("test random done");
    // mid-run reset must restore defaults and leave writes working
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    e = '{24'h0001C0, 24'h003001, 24'h001802};
    @(posedge mclk);
    cmp();
    put(24'h0004C0, 24);
    $display("test rerun done");
    end_sim();
  end
endmodule
`default_nettype wire
